// [cwp_top.sv]
// Wake-up and power control sequencer of a caller-ID receiver
`timescale 1ns/1ns
//
// Overview of operation
// [R1] A recognised ring wakes the receiver without host action.
// [R2] Power down after message done, bad format, or no modulated signal.
// [R3] Host may wake the receiver; it then demodulates and extracts.
// [R4] Host holds external wake low at least 5 us before releasing.
// [R5] External wake starts on the rising edge ending the low pulse.
// [R6] Ring sense also sees reversals; these refresh supply status only.
// [R7] Internal wake follows a delay from ring end set by the RC node.
// [R8] Operating mode is captured while the ring delay node is low.
// [R9] Dialer mode and host mode are both supported.
// [R10] Caller message timing is sequenced internally, no controller tracking.
// [R11] Strap high selects host mode, low selects dialer mode.
// [R12] Sleep/reset high resets and sleeps; ring sensing keeps working.
// [R13] Supply-low flag updates at end of reversal, ring or external wake.
// [R14] Both wake sources share one power-up with oscillator settle wait.
module cwp_top #(
  parameter int unsigned RING_MIN_CYC   = 64,
  parameter int unsigned OSC_SETTLE     = cwp_pkg::OSC_SETTLE_CYC,
  parameter int unsigned NO_SIG_TIMEOUT = cwp_pkg::NO_SIG_CYC
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  input  wire logic sleep_reset_i,
  input  wire logic ring_sense_input_i,
  input  wire logic ring_delay_node_i,
  input  wire logic external_wake_n_i,
  input  wire logic data_or_mode_strap_i,
  input  wire logic supply_ok_i,
  input  wire logic modulated_present_i,
  input  wire logic message_done_i,
  input  wire logic format_error_i,
  output logic      ring_delay_node_o,
  output logic      ring_delay_node_oe_o,
  output logic      osc_enable_o,
  output logic      demod_enable_o,
  output logic      host_mode_o,
  output logic      supply_low_flag_n_o,
  output logic      awake_o
);
  import cwp_pkg::*;

  localparam logic [CNT_W-1:0] RING_MIN = CNT_W'(RING_MIN_CYC);
  localparam logic [CNT_W-1:0] SETTLE   = CNT_W'(OSC_SETTLE);
  localparam logic [CNT_W-1:0] NO_SIG   = CNT_W'(NO_SIG_TIMEOUT);

  cwp_state_t       state_q, state_d;
  logic [2:0]       ring_sync_q, wake_sync_q, rc_sync_q, strap_sync_q;
  logic             ring_q, wake_q, rc_q, strap_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             host_mode_q, supply_low_n_q;
  logic             heard_q;

  // Three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ring_sync_q  <= 3'h0;
      wake_sync_q  <= 3'h7;
      rc_sync_q    <= 3'h7;
      strap_sync_q <= 3'h0;
    end else if (clk_en_i) begin
      ring_sync_q  <= {ring_sync_q[1:0], ring_sense_input_i};
      wake_sync_q  <= {wake_sync_q[1:0], external_wake_n_i};
      rc_sync_q    <= {rc_sync_q[1:0], ring_delay_node_i};
      strap_sync_q <= {strap_sync_q[1:0], data_or_mode_strap_i};
    end
  end

  // Filtered levels: only update when the last two stages agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ring_q  <= 1'b0;
      wake_q  <= 1'b1;
      rc_q    <= 1'b1;
      strap_q <= 1'b0;
    end else if (clk_en_i) begin
      if (ring_sync_q[1] == ring_sync_q[2]) ring_q <= ring_sync_q[2];
      if (wake_sync_q[1] == wake_sync_q[2]) wake_q <= wake_sync_q[2];
      if (rc_sync_q[1] == rc_sync_q[2]) rc_q <= rc_sync_q[2];
      if (strap_sync_q[1] == strap_sync_q[2]) strap_q <= strap_sync_q[2];
    end
  end

  // Edge events on the filtered levels
  wire ring_new   = ring_sync_q[1] == ring_sync_q[2];
  wire ring_fall  = ring_q & ring_new & ~ring_sync_q[2];
  wire wake_new   = wake_sync_q[1] == wake_sync_q[2];
  wire wake_rise  = ~wake_q & wake_new & wake_sync_q[2];            // see [R5]
  wire rc_high    = rc_q;
  wire sleeping   = state_q == CWP_SLEEP;
  // Ring burst long enough counts as a ring; shorter activity is a reversal
  wire is_ring    = cnt_q >= RING_MIN;
  wire ring_end   = (state_q == CWP_RING_ACT) & ring_fall;
  wire reversal   = ring_end & ~is_ring;                            // see [R6]
  wire ring_valid = ring_end & is_ring;                             // see [R1]
  // External wake only counts from sleep; later pulses are ignored
  wire ext_wake   = sleeping & wake_rise & ~sleep_reset_i;          // see [R3]
  wire supply_evt = reversal | ring_valid | ext_wake;               // see [R13]
  wire stop_run   = message_done_i | format_error_i |
                    (~heard_q & (cnt_q >= NO_SIG));                 // see [R2]
  wire cnt_max    = &cnt_q;

  // Sequencer next state; sleep/reset blocks host wake and forces sleep outside the ring states
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_max ? cnt_q : cnt_q + CNT_W'(1);
    case (state_q)
      CWP_SLEEP: begin
        cnt_d = '0;
        // Host wake wins over a ring seen in the same cycle, so its pulse is never lost
        if (ext_wake) state_d = CWP_OSC_WAIT;                       // see [R14]
        else if (ring_q & ring_new) state_d = CWP_RING_ACT;         // see [R1]
      end
      CWP_RING_ACT: begin
        if (reversal) state_d = CWP_SLEEP;                          // see [R6]
        else if (ring_valid) begin
          state_d = CWP_RING_DLY;
          cnt_d   = '0;
        end
      end
      CWP_RING_DLY: begin
        // RC node released high ends the delay and triggers wake
        if (ring_q) state_d = CWP_RING_ACT;
        else if (rc_high & (cnt_q != '0)) begin                     // see [R7]
          state_d = CWP_OSC_WAIT;
          cnt_d   = '0;
        end
      end
      CWP_OSC_WAIT: begin
        if (cnt_q >= SETTLE) begin                                  // see [R14]
          state_d = CWP_RUN;
          cnt_d   = '0;
        end
      end
      CWP_RUN: begin
        // Message timing is run here so the controller does not track it
        if (stop_run) state_d = CWP_SLEEP;                          // see [R10]
      end
      default: state_d = CWP_SLEEP;
    endcase
    if (sleep_reset_i & ~sleeping & (state_q != CWP_RING_ACT) &
        (state_q != CWP_RING_DLY)) begin                            // see [R12]
      state_d = CWP_SLEEP;
      cnt_d   = '0;
    end
  end

  // Sequencer state, counter and no-signal tracking
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= CWP_SLEEP;
      cnt_q   <= '0;
      heard_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (state_q != CWP_RUN) heard_q <= 1'b0;
      else if (modulated_present_i) heard_q <= 1'b1;
    end
  end

  // Mode strap captured while the RC node is low; supply flag on events
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_mode_q    <= MODE_DIALER;
      supply_low_n_q <= 1'b1;
    end else if (clk_en_i) begin
      if (state_q == CWP_RING_DLY && !rc_q)
        host_mode_q <= strap_q ? MODE_HOST : MODE_DIALER;           // see [R8], [R11]
      if (supply_evt) supply_low_n_q <= supply_ok_i;                // see [R13]
    end
  end

  // RC node: open drain held low during ring activity, released in delay
  assign ring_delay_node_o    = 1'b0;
  assign ring_delay_node_oe_o = state_q == CWP_RING_ACT;            // see [R7]
  assign osc_enable_o         = (state_q == CWP_OSC_WAIT) | (state_q == CWP_RUN);
  assign demod_enable_o       = state_q == CWP_RUN;                 // see [R3], [R9]
  assign host_mode_o          = host_mode_q;                        // see [R9]
  assign supply_low_flag_n_o  = supply_low_n_q;
  assign awake_o              = ~sleeping;

  // Cycles the oscillator has run, saturating; lets a check see the settle wait
  logic [CNT_W-1:0] osc_run_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_run_q <= '0;
    end else if (clk_en_i) begin
      if (!osc_enable_o) osc_run_q <= '0;
      else if (!(&osc_run_q)) osc_run_q <= osc_run_q + CNT_W'(1);
    end
  end

  // Checks
  ring_wake_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R1]
    clk_en_i & ring_valid & ~sleep_reset_i |=> state_q == CWP_RING_DLY)
    else $error("valid ring did not start delay");
  rev_sleep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R6]
    clk_en_i & reversal |=> state_q == CWP_SLEEP)
    else $error("reversal woke device");
  stop_run_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R2]
    clk_en_i & (state_q == CWP_RUN) & stop_run |=> sleeping)
    else $error("run did not stop");
  wake_edge_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R5]
    clk_en_i & ext_wake |=> state_q == CWP_OSC_WAIT)
    else $error("external wake not taken at release");
  sequence settle_s;
    (state_q == CWP_OSC_WAIT) & clk_en_i & (cnt_q >= SETTLE);
  endsequence
  osc_settle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R14]
    settle_s ##0 ~sleep_reset_i |=> demod_enable_o & osc_enable_o)
    else $error("demod not enabled after settle");
  no_demod_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R14]
    $rose(demod_enable_o) |-> osc_run_q > SETTLE)
    else $error("demod before oscillator settled");
  mode_cap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R8]
    clk_en_i & (state_q == CWP_RING_DLY) & ~rc_q |=> host_mode_q == $past(strap_q))
    else $error("mode not captured");
  supply_upd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R13]
    clk_en_i & supply_evt |=> supply_low_flag_n_o == $past(supply_ok_i))
    else $error("supply flag not updated");
  sleep_rst_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R12]
    clk_en_i & sleep_reset_i & (state_q == CWP_RUN) |=> ~osc_enable_o)
    else $error("sleep input ignored");
endmodule // cwp_top

// [cwp_pkg.sv]
// Package of constants and types for the wake and power control sequencer
package cwp_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  // Least external wake low time, in microseconds
  localparam int unsigned EXT_WAKE_MIN_US  = 5;
  localparam int unsigned EXT_WAKE_MIN_CYC =
    (EXT_WAKE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default oscillator settle time, in microseconds
  localparam int unsigned OSC_SETTLE_US    = 2;
  localparam int unsigned OSC_SETTLE_CYC   =
    (OSC_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default no-signal timeout, in cycles
  localparam int unsigned NO_SIG_CYC       = 1000;
  localparam int unsigned CNT_W            = 16;
  // Mode strap encoding
  localparam logic        MODE_DIALER      = 1'b0;
  localparam logic        MODE_HOST        = 1'b1;

  typedef enum logic [2:0] {
    CWP_SLEEP,
    CWP_RING_ACT,
    CWP_RING_DLY,
    CWP_OSC_WAIT,
    CWP_RUN
  } cwp_state_t;
endpackage : cwp_pkg

// [cwp_line_model.sv]
// Model of the line ring circuitry and the host wake source
`timescale 1ns/1ns
module cwp_line_model #(
  parameter int unsigned RC_CYC = 30
) (
  input  wire logic clk_i,
  input  wire logic node_pull_i,
  input  wire logic node_drv_i,
  output logic      node_o,
  output logic      ring_o,
  output logic      wake_n_o,
  output logic      strap_o
);
  int unsigned charge_q = RC_CYC;
  // Capacitor charges through the pull-up only after the device lets go
  always @(posedge clk_i) begin
    if (node_pull_i && !node_drv_i) charge_q <= 0;
    else if (charge_q < RC_CYC) charge_q <= charge_q + 1;
  end
  // Open drain: the driven level wins while enabled, else the RC pull-up level
  assign node_o = node_pull_i ? node_drv_i : (charge_q >= RC_CYC);
  initial begin
    ring_o   = 1'b0;
    wake_n_o = 1'b1;
    strap_o  = 1'b0;
  end
  // Ring or reversal burst; the strap level stays put until the next burst
  task automatic line_burst(input int n, input logic mode);
    @(posedge clk_i);
    #1 strap_o = mode;
    ring_o = 1'b1;
    repeat (n) @(posedge clk_i);
    #1 ring_o = 1'b0;
  endtask
  // Host wake pulse, low for n cycles
  task automatic wake_pulse(input int n);
    @(posedge clk_i);
    #1 wake_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #1 wake_n_o = 1'b1;
  endtask
endmodule // cwp_line_model

// [testbench.sv]
// Self-checking testbench of the wake and power control sequencer
`timescale 1ns/1ns
module testbench;
  import cwp_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sleep_reset_i = 1'b0;
  logic supply_ok_i = 1'b1;
  logic modulated_present_i = 1'b0;
  logic message_done_i = 1'b0;
  logic format_error_i = 1'b0;
  logic node, ring, wake_n, strap, node_oe, node_drv;
  logic osc_enable_o, demod_enable_o, host_mode_o, supply_low_flag_n_o, awake_o;
  logic [1:0] exp_q[$];
  logic last_mode = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  int seed = 23;
  always #4 clk_i = ~clk_i;
  cwp_top #(.OSC_SETTLE(4), .NO_SIG_TIMEOUT(20)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .sleep_reset_i(sleep_reset_i), .ring_sense_input_i(ring),
    .ring_delay_node_i(node), .external_wake_n_i(wake_n), .data_or_mode_strap_i(strap),
    .supply_ok_i(supply_ok_i), .modulated_present_i(modulated_present_i),
    .message_done_i(message_done_i), .format_error_i(format_error_i),
    .ring_delay_node_o(node_drv), .ring_delay_node_oe_o(node_oe), .osc_enable_o(osc_enable_o),
    .demod_enable_o(demod_enable_o), .host_mode_o(host_mode_o),
    .supply_low_flag_n_o(supply_low_flag_n_o), .awake_o(awake_o));
  cwp_line_model line (.clk_i(clk_i), .node_pull_i(node_oe), .node_drv_i(node_drv),
    .node_o(node), .ring_o(ring),
    .wake_n_o(wake_n), .strap_o(strap));
  task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for awake (sel 0) or demod enable (sel 1) to reach a level
  task automatic wait_lvl(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? awake_o : demod_enable_o) !== lvl && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(sel ? "demod" : "awake", sel ? demod_enable_o : awake_o, lvl);
  endtask
  // Mode and supply flag seen as soon as the oscillator starts; a wake with no note fails
  always @(posedge osc_enable_o) begin
    #1;
    if (exp_q.size() == 0) chk("spare_wake", 2'h1, 2'h0);
    else chk("mode_flag", {host_mode_o, supply_low_flag_n_o}, exp_q.pop_front());
  end
  // Wake by ring or by host, then end the run in one of four ways
  task automatic run_case(input int kind, input logic mode, input int how);
    supply_ok_i = 1'($random(seed));
    if (kind == 1) last_mode = mode;
    exp_q.push_back({last_mode, supply_ok_i});
    if (kind == 1) line.line_burst(80, mode);
    else begin
      line.wake_pulse(EXT_WAKE_MIN_CYC);
      chk("awake_at_release", awake_o, 1'b0);
    end
    modulated_present_i = (how != 2);
    wait_lvl(1, 1'b1, 100);
    @(posedge clk_i);
    #1 message_done_i = (how == 0);
    format_error_i = (how == 1);
    sleep_reset_i = (how == 3);
    repeat (2) @(posedge clk_i);
    #1 {message_done_i, format_error_i, sleep_reset_i, modulated_present_i} = 4'h0;
    wait_lvl(0, 1'b0, 40);
  endtask
  initial begin
    logic woke;
    woke = 1'b0;
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    for (int i = 0; i < 4; i++) run_case(i % 2, 1'(i / 2), i);
    // Short burst under sleep/reset is a reversal: ring sensing still refreshes the flag
    supply_ok_i = ~supply_ok_i;
    sleep_reset_i = 1'b1;
    line.line_burst(10, 1'b1);
    // Watch the whole window, a misread ring would start the oscillator only briefly
    repeat (60) begin
      @(posedge clk_i);
      #1 woke = woke | osc_enable_o;
    end
    sleep_reset_i = 1'b0;
    chk("reversal_osc", woke, 1'b0);
    chk("reversal_flag", supply_low_flag_n_o, supply_ok_i);
    chk("notes_left", {1'b0, exp_q.size() != 0}, 2'h0);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
endmodule // testbench
